/* File: pkg/dso_pkg.sv */
// Shared constants and types of the dual-slope converter output sequencer.
package dso_pkg;

    // ------------------------------------------------------------
    // Clocking
    // ------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_NS = 40;
    // System clocks per converter count; the half count carries the strobe.
    localparam int unsigned COUNT_DIV     = 2;
    localparam int unsigned DIV_W         = 1;
    localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(COUNT_DIV - 1);
    localparam logic [DIV_W-1:0] DIV_HALF = DIV_W'(COUNT_DIV / 2);

    // ------------------------------------------------------------
    // Measurement cycle, in converter counts
    // ------------------------------------------------------------
    localparam logic [15:0] CYCLE_COUNTS   = 16'h9c42;
    localparam logic [15:0] INT_COUNTS     = 16'h2710;
    localparam logic [14:0] FULL_SCALE     = 15'h4e20;
    localparam logic [14:0] UNDER_LIMIT    = 15'h0708;
    localparam logic [15:0] ZI_SHORT       = 16'h00c8;
    localparam logic [15:0] ZI_LONG        = 16'h1838;

    // ------------------------------------------------------------
    // Digit scan, in converter counts
    // ------------------------------------------------------------
    localparam logic [2:0]  NUM_DIGITS     = 3'h5;
    localparam logic [2:0]  STROBE_TOTAL   = 3'h5;
    localparam logic [7:0]  MSD_SLOT_LEN   = 8'hc9;
    localparam logic [7:0]  DIGIT_SLOT_LEN = 8'hc8;
    localparam logic [7:0]  STROBE_SLOT    = 8'h64;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        PH_ZERO_OFFSET,
        PH_SIGNAL_INTEGRATE,
        PH_REFERENCE_INTEGRATE,
        PH_INTEGRATOR_RESET
    } dso_phase_t;

endpackage

/* File: logic/dso_count_divider.sv */
// Divider that makes the converter count enable and its half-count enable.
`timescale 1ns/10ps
module dso_count_divider (
    // Clock and reset
    input  wire logic sys_clk,
    input  wire logic rst_n,
    // Enables
    output logic      tick,
    output logic      mid
);
    import dso_pkg::*;

    typedef struct packed {
        logic [DIV_W-1:0] cnt;
        logic             tick;
        logic             mid;
    } dso_div_state_t;

    dso_div_state_t s_r;
    dso_div_state_t s_nxt;

    always_comb begin
        s_nxt = s_r;
        if (s_r.cnt == DIV_LAST) begin
            s_nxt.cnt = '0;
        end else begin
            s_nxt.cnt = s_r.cnt + 1'b1;
        end
        s_nxt.tick = (s_nxt.cnt == '0);
        s_nxt.mid  = (s_nxt.cnt == DIV_HALF);
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign tick = s_r.tick;
    assign mid  = s_r.mid;
endmodule

/* File: logic/dso_digit_scanner.sv */
// Multiplexed digit scan, BCD presentation and latch strobes.
`timescale 1ns/10ps
module dso_digit_scanner (
    // Clock and reset
    input  wire logic        sys_clk,
    input  wire logic        rst_n,
    // Enables and events
    input  wire logic        tick,
    input  wire logic        mid,
    input  wire logic        meas_end,
    input  wire logic        de_start,
    input  wire logic        ovr,
    input  wire logic [19:0] result,
    // Display outputs
    output logic [4:0]       sel,
    output logic [3:0]       bcd,
    output logic             strobe_n
);
    import dso_pkg::*;

    typedef struct packed {
        logic [2:0] dig;
        logic [7:0] slot;
        logic [2:0] left;
        logic       seq;
        logic       lng;
        logic       blank;
        logic       go_de;
        logic [4:0] sel;
        logic [3:0] bcd;
        logic       strobe_n;
    } dso_scan_state_t;

    dso_scan_state_t s_r;
    dso_scan_state_t s_nxt;

    function automatic logic [4:0] onehot(input logic [2:0] d);
        onehot = 5'h10 >> d;
    endfunction

    always_comb begin
        s_nxt = s_r;
        s_nxt.strobe_n = 1'b1;
        // Delayed by one clock so the restart falls on a whole count.
        s_nxt.go_de    = de_start;
        if (meas_end) begin
            s_nxt.dig   = '0;
            s_nxt.slot  = '0;
            s_nxt.lng   = 1'b1;
            s_nxt.left  = STROBE_TOTAL;
            s_nxt.seq   = 1'b1;
            s_nxt.blank = 1'b0;
        end else if (s_r.go_de && s_r.blank) begin
            s_nxt.dig   = '0;
            s_nxt.slot  = '0;
            s_nxt.lng   = 1'b0;
            s_nxt.blank = 1'b0;
        end else begin
            if (tick && !s_r.blank) begin
                if (s_r.slot == (s_r.lng ? MSD_SLOT_LEN : DIGIT_SLOT_LEN) - 8'h01) begin
                    s_nxt.slot = '0;
                    s_nxt.lng  = 1'b0;
                    if (s_r.dig == NUM_DIGITS - 3'h1) begin
                        s_nxt.dig = '0;
                        if (s_r.seq && s_r.left == '0) begin
                            s_nxt.seq = 1'b0;
                            s_nxt.blank = ovr;
                        end
                    end else begin
                        s_nxt.dig = s_r.dig + 3'h1;
                    end
                end else begin
                    s_nxt.slot = s_r.slot + 8'h01;
                end
            end
            if (mid && !s_r.blank && s_r.seq && s_r.left != '0 && s_r.slot == STROBE_SLOT) begin
                s_nxt.strobe_n = 1'b0;
                s_nxt.left     = s_r.left - 3'h1;
            end
        end
        s_nxt.sel = s_nxt.blank ? 5'h00 : onehot(s_nxt.dig);
        s_nxt.bcd = s_nxt.blank ? 4'h0 : result[5'(16 - 4 * s_nxt.dig) +: 4];
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            s_r          <= '0;
            s_r.strobe_n <= 1'b1;
            s_r.sel      <= 5'h10;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign sel      = s_r.sel;
    assign bcd      = s_r.bcd;
    assign strobe_n = s_r.strobe_n;
endmodule

/* File: logic/dso_sequencer_top.sv */
// Measurement sequencer, result latch and flags of the dual-slope converter.
// What this block does
// - Five low strobes per finished measurement, first 101 counts after its end.
// - Most significant digit select rises at measurement end, lasts 201 counts.
// - Each strobe is low half a count, centred inside its digit select.
// - Later digits last 200 counts; strobe falls 100 counts after each rises.
// - Scanning continues after fifth strobe; no more strobes until a new result.
// - Busy rises at integrate start, falls after crossing or overrange end.
// - Result latches load during the first count after busy falls.
// - Busy low exactly when in offset-zero or integrator-reset phase.
// - Overrange set at busy end above 20,000; cleared at next reference start.
// - Underrange set at busy end at 1800 or less; cleared at integrate start.
// - Polarity high for positive or zero; updated at reference integrate start.
// - Digit selects are 200-count pulses, 201 for the MSD after a result, scanned from digit five to one.
// - On overrange, selects blank after strobes until reference integrate restarts scan.
// - BCD outputs are active high and change with the digit select.
// - Comparator sampled once per count after clock transients settle.
// - Counter skips the first count of reference integrate.
// - Overrange reading shows 0000, not 0001.
// - No count delay at the start of signal integrate.
// - Phases run offset-zero, signal integrate, reference integrate, integrator reset.
// - With run/hold high, a new cycle starts every 40,002 counts.
// - Integrator reset lasts 200 counts, 6200 after an overrange.
// - Run/hold low holds; a high level starts only after a full cycle.
`timescale 1ns/10ps
module dso_sequencer_top #(
    parameter logic [15:0] P_CYCLE   = dso_pkg::CYCLE_COUNTS,
    parameter logic [15:0] P_INT     = dso_pkg::INT_COUNTS,
    parameter logic [14:0] P_FULL    = dso_pkg::FULL_SCALE,
    parameter logic [15:0] P_ZI_LONG = dso_pkg::ZI_LONG
) (
    // Clock and reset
    input  wire logic SYS_CLK,
    input  wire logic RSTN,
    // Converter pins
    input  wire logic RUN_HOLD,
    input  wire logic COMP_CROSSED,
    input  wire logic INPUT_POSITIVE,
    // Phase controls
    output logic      PHASE_ZERO_OFFSET,
    output logic      PHASE_SIGNAL_INTEGRATE,
    output logic      PHASE_REFERENCE_INTEGRATE,
    output logic      PHASE_INTEGRATOR_RESET,
    // Status
    output logic      BUSY,
    output logic      OVERRANGE,
    output logic      UNDERRANGE,
    output logic      POLARITY,
    // Display
    output logic      DIGIT_SEL_MSD,
    output logic      DIGIT_SEL_FOURTH,
    output logic      DIGIT_SEL_THIRD,
    output logic      DIGIT_SEL_SECOND,
    output logic      DIGIT_SEL_LSD,
    output logic      BCD_WEIGHT_EIGHT,
    output logic      BCD_WEIGHT_FOUR,
    output logic      BCD_WEIGHT_TWO,
    output logic      BCD_WEIGHT_ONE,
    output logic      STROBE_N
);
    import dso_pkg::*;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic        run_m;
        logic        run_s;
        logic        cmp_m;
        logic        cmp_s;
        logic        sgn_m;
        logic        sgn_s;
        dso_phase_t  phase;
        logic [15:0] cyc;
        logic [15:0] pcnt;
        logic [14:0] bin;
        logic [19:0] bcd;
        logic        skip;
        logic        zi_long;
        logic        load;
        logic        ovr_conv;
        logic [19:0] result;
        logic        busy;
        logic        ovr;
        logic        und;
        logic        pol;
        logic        meas_end;
        logic        de_start;
        logic [3:0]  ph_out;
    } dso_seq_state_t;

    dso_seq_state_t s_r;
    dso_seq_state_t s_nxt;

    logic       tick;
    logic       mid;
    logic [4:0] sel;
    logic [3:0] bcd;
    logic       strobe_n;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Decimal counting avoids a binary to BCD converter on the result path.
    function automatic logic [19:0] bcd_inc(input logic [19:0] v);
        logic [19:0] r;
        logic        c;
        r = v;
        c = 1'b1;
        for (int i = 0; i < 5; i++) begin
            if (c) begin
                if (r[i*4 +: 4] == 4'h9) begin
                    r[i*4 +: 4] = 4'h0;
                end else begin
                    r[i*4 +: 4] = r[i*4 +: 4] + 4'h1;
                    c = 1'b0;
                end
            end
        end
        bcd_inc = r;
    endfunction

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        s_nxt = s_r;
        // Pins are asynchronous to the system clock.
        s_nxt.run_m    = RUN_HOLD;
        s_nxt.run_s    = s_r.run_m;
        s_nxt.cmp_m    = COMP_CROSSED;
        s_nxt.cmp_s    = s_r.cmp_m;
        s_nxt.sgn_m    = INPUT_POSITIVE;
        s_nxt.sgn_s    = s_r.sgn_m;
        s_nxt.meas_end = 1'b0;
        s_nxt.de_start = 1'b0;
        // Latching on the half count lets the scan restart on a whole count.
        if (mid && s_r.load) begin
            s_nxt.result   = s_r.ovr_conv ? 20'h00000 : s_r.bcd;
            s_nxt.load     = 1'b0;
            s_nxt.meas_end = 1'b1;
        end
        if (tick) begin
            if (s_r.cyc != P_CYCLE - 16'h0001) begin
                s_nxt.cyc = s_r.cyc + 16'h0001;
            end
            case (s_r.phase)
                PH_ZERO_OFFSET: begin
                    if (s_r.cyc == P_CYCLE - 16'h0001 && s_r.run_s) begin
                        s_nxt.phase = PH_SIGNAL_INTEGRATE;
                        s_nxt.cyc   = '0;
                        s_nxt.pcnt  = '0;
                        s_nxt.bin   = '0;
                        s_nxt.bcd   = '0;
                        s_nxt.und   = 1'b0;
                    end
                end
                PH_SIGNAL_INTEGRATE: begin
                    s_nxt.pcnt = s_r.pcnt + 16'h0001;
                    if (s_r.pcnt == P_INT - 16'h0001) begin
                        s_nxt.phase    = PH_REFERENCE_INTEGRATE;
                        s_nxt.pcnt     = '0;
                        s_nxt.skip     = 1'b1;
                        s_nxt.de_start = 1'b1;
                        s_nxt.pol      = s_r.sgn_s;
                        s_nxt.ovr      = 1'b0;
                    end
                end
                PH_REFERENCE_INTEGRATE: begin
                    s_nxt.skip = 1'b0;
                    if (s_r.cmp_s || (!s_r.skip && s_r.bin == P_FULL)) begin
                        s_nxt.phase    = PH_INTEGRATOR_RESET;
                        s_nxt.pcnt     = '0;
                        s_nxt.load     = 1'b1;
                        s_nxt.ovr_conv = !s_r.cmp_s;
                        s_nxt.zi_long  = !s_r.cmp_s;
                        s_nxt.ovr      = !s_r.cmp_s;
                        s_nxt.und      = s_r.cmp_s && (s_r.bin <= UNDER_LIMIT);
                    end else if (!s_r.skip) begin
                        s_nxt.bin = s_r.bin + 15'h0001;
                        s_nxt.bcd = bcd_inc(s_r.bcd);
                    end
                end
                PH_INTEGRATOR_RESET: begin
                    s_nxt.pcnt = s_r.pcnt + 16'h0001;
                    if (s_r.pcnt == (s_r.zi_long ? P_ZI_LONG : ZI_SHORT) - 16'h0001) begin
                        s_nxt.phase   = PH_ZERO_OFFSET;
                        s_nxt.zi_long = 1'b0;
                    end
                end
                default: begin
                    s_nxt.phase = PH_ZERO_OFFSET;
                end
            endcase
        end
        s_nxt.busy = (s_nxt.phase == PH_SIGNAL_INTEGRATE) ||
                     (s_nxt.phase == PH_REFERENCE_INTEGRATE);
        s_nxt.ph_out = 4'h1 << s_nxt.phase;
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge SYS_CLK or negedge RSTN) begin
        if (!RSTN) begin
            s_r        <= '0;
            s_r.cyc    <= P_CYCLE - 16'h0001;
            s_r.pol    <= 1'b1;
            s_r.ph_out <= 4'h1;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ------------------------------------------------------------
    // Count enables and digit scan
    // ------------------------------------------------------------
    dso_count_divider u_div (
        .sys_clk (SYS_CLK),
        .rst_n   (RSTN),
        .tick    (tick),
        .mid     (mid)
    );

    dso_digit_scanner u_scan (
        .sys_clk  (SYS_CLK),
        .rst_n    (RSTN),
        .tick     (tick),
        .mid      (mid),
        .meas_end (s_r.meas_end),
        .de_start (s_r.de_start),
        .ovr      (s_r.ovr),
        .result   (s_r.result),
        .sel      (sel),
        .bcd      (bcd),
        .strobe_n (strobe_n)
    );

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign PHASE_ZERO_OFFSET         = s_r.ph_out[0];
    assign PHASE_SIGNAL_INTEGRATE    = s_r.ph_out[1];
    assign PHASE_REFERENCE_INTEGRATE = s_r.ph_out[2];
    assign PHASE_INTEGRATOR_RESET    = s_r.ph_out[3];
    assign BUSY                      = s_r.busy;
    assign OVERRANGE                 = s_r.ovr;
    assign UNDERRANGE                = s_r.und;
    assign POLARITY                  = s_r.pol;
    assign DIGIT_SEL_MSD             = sel[4];
    assign DIGIT_SEL_FOURTH          = sel[3];
    assign DIGIT_SEL_THIRD           = sel[2];
    assign DIGIT_SEL_SECOND          = sel[1];
    assign DIGIT_SEL_LSD             = sel[0];
    assign BCD_WEIGHT_EIGHT          = bcd[3];
    assign BCD_WEIGHT_FOUR           = bcd[2];
    assign BCD_WEIGHT_TWO            = bcd[1];
    assign BCD_WEIGHT_ONE            = bcd[0];
    assign STROBE_N                  = strobe_n;
endmodule

/* File: testbench/dso_sequencer_sva.sv */
// Port-level assertions for the converter output sequencer.
`timescale 1ns/10ps
module dso_sequencer_sva #(
    parameter logic [15:0] P_ZI_LONG = dso_pkg::ZI_LONG
) (
    // Clock and reset
    input wire logic SYS_CLK, RSTN,
    // Converter pins
    input wire logic RUN_HOLD, COMP_CROSSED, INPUT_POSITIVE,
    // Phases and status
    input wire logic PHASE_ZERO_OFFSET, PHASE_SIGNAL_INTEGRATE, PHASE_REFERENCE_INTEGRATE,
    input wire logic PHASE_INTEGRATOR_RESET, BUSY, OVERRANGE, UNDERRANGE, POLARITY,
    // Display
    input wire logic DIGIT_SEL_MSD, DIGIT_SEL_FOURTH, DIGIT_SEL_THIRD, DIGIT_SEL_SECOND,
    input wire logic DIGIT_SEL_LSD, BCD_WEIGHT_EIGHT, BCD_WEIGHT_FOUR, BCD_WEIGHT_TWO,
    input wire logic BCD_WEIGHT_ONE, STROBE_N
);
    import dso_pkg::*;
    logic [4:0] sel;
    logic [3:0] bcd;
    int         zi_len;
    assign sel = {DIGIT_SEL_MSD, DIGIT_SEL_FOURTH, DIGIT_SEL_THIRD,
                  DIGIT_SEL_SECOND, DIGIT_SEL_LSD};
    assign bcd = {BCD_WEIGHT_EIGHT, BCD_WEIGHT_FOUR, BCD_WEIGHT_TWO, BCD_WEIGHT_ONE};
    // Length is kept in system clocks, two of them per count.
    always_ff @(posedge SYS_CLK or negedge RSTN) begin
        if (!RSTN) begin
            zi_len <= 0;
        end else begin
            zi_len <= PHASE_INTEGRATOR_RESET ? zi_len + 1 : 0;
        end
    end
    default clocking cb @(posedge SYS_CLK);
    endclocking
    default disable iff (!RSTN);
    AST_BUSY_IS_MEASURE: assert property (
        BUSY == (PHASE_SIGNAL_INTEGRATE || PHASE_REFERENCE_INTEGRATE))
        else $error("Busy differs from the measuring phases");
    AST_ONE_PHASE: assert property ($onehot({PHASE_ZERO_OFFSET,
        PHASE_SIGNAL_INTEGRATE, PHASE_REFERENCE_INTEGRATE, PHASE_INTEGRATOR_RESET}))
        else $error("Phase outputs not one-hot");
    AST_REF_AFTER_INT: assert property (
        $rose(PHASE_REFERENCE_INTEGRATE) |-> $past(PHASE_SIGNAL_INTEGRATE))
        else $error("Reference phase not preceded by integrate");
    AST_UNDER_CLEAR: assert property (
        $rose(PHASE_SIGNAL_INTEGRATE) |-> ##[0:2] !UNDERRANGE)
        else $error("Underrange not cleared at integrate start");
    AST_OVR_CLEAR: assert property (
        $rose(PHASE_REFERENCE_INTEGRATE) |-> ##[0:2] !OVERRANGE)
        else $error("Overrange not cleared at reference start");
    AST_FLAG_SET: assert property (
        $rose(OVERRANGE) || $rose(UNDERRANGE) |-> $fell(BUSY))
        else $error("Range flag set away from busy end");
    AST_POL_HOLD: assert property (
        $changed(POLARITY) |-> PHASE_REFERENCE_INTEGRATE)
        else $error("Polarity moved outside reference start");
    AST_STROBE_HALF: assert property (
        $fell(STROBE_N) |=> STROBE_N)
        else $error("Strobe low longer than one clock");
    AST_STROBE_MID: assert property (
        !STROBE_N |-> sel != 5'h00 && $stable(sel) && $stable(bcd) ##1 $stable({sel, bcd}))
        else $error("Select or data moved around the strobe");
    AST_SEL_ONEHOT: assert property ($onehot0(sel))
        else $error("More than one digit selected");
    AST_BCD_WITH_SEL: assert property (
        (bcd <= 4'h9) and ($changed(bcd) |-> $changed(sel) || DIGIT_SEL_MSD))
        else $error("Digit data changed without its select");
    AST_ZI_LEN: assert property (
        $fell(PHASE_INTEGRATOR_RESET) |-> zi_len == 2 * ZI_SHORT || zi_len == 2 * P_ZI_LONG)
        else $error("Integrator reset length wrong");
    cover property ($fell(STROBE_N));
    cover property ($rose(OVERRANGE));
    cover property ($fell(BUSY) && !POLARITY);
endmodule

bind dso_sequencer_top dso_sequencer_sva #(.P_ZI_LONG(P_ZI_LONG)) u_sva (
    .SYS_CLK, .RSTN, .RUN_HOLD, .COMP_CROSSED, .INPUT_POSITIVE, .PHASE_ZERO_OFFSET,
    .PHASE_SIGNAL_INTEGRATE, .PHASE_REFERENCE_INTEGRATE, .PHASE_INTEGRATOR_RESET, .BUSY,
    .OVERRANGE, .UNDERRANGE, .POLARITY, .DIGIT_SEL_MSD, .DIGIT_SEL_FOURTH, .DIGIT_SEL_THIRD,
    .DIGIT_SEL_SECOND, .DIGIT_SEL_LSD, .BCD_WEIGHT_EIGHT, .BCD_WEIGHT_FOUR, .BCD_WEIGHT_TWO,
    .BCD_WEIGHT_ONE, .STROBE_N);

/* File: testbench/dso_front_model.sv */
// Comparator and strobe-driven data receiver on the far side of the sequencer.
`timescale 1ns/10ps
module dso_front_model (
    // Converter side
    input  wire logic        sys_clk,
    input  wire logic        phase_ref,
    input  wire logic        phase_idle,
    input  wire logic [15:0] target,
    output logic             crossed,
    // Data receiver
    input  wire logic        strobe_n,
    input  wire logic [3:0]  bcd,
    output int               strobes,
    output int               value
);
    int   ref_clks = 0;
    logic cross_r  = 1'b0;
    assign crossed = cross_r;
    // A negative target never crosses; idle phases toggle the line on purpose.
    always @(posedge sys_clk) begin
        ref_clks <= phase_ref ? ref_clks + 1 : 0;
        if (phase_ref) begin
            cross_r <= !target[15] && (ref_clks >= 2 * $signed(target) - 1);
        end else begin
            cross_r <= phase_idle && !cross_r;
        end
    end
    always @(posedge sys_clk) begin
        if (phase_ref) begin
            strobes <= 0;
            value   <= 0;
        end else if (!strobe_n) begin
            strobes <= strobes + 1;
            value   <= value * 10 + int'(bcd);
        end
    end
endmodule

/* File: testbench/dso_sequencer_top_bench.sv */
// Self-checking bench of the converter output sequencer.
`timescale 1ns/10ps
`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin fail_count++; \
    $display("Error at %0t: got %h expected %h", $time, (got), (exp)); end end
module dso_sequencer_top_bench;
    import dso_pkg::*;
    // Shortened counts keep the run brief; all in-range readings stay underrange.
    localparam int P_INT = 100;
    localparam int P_FULL = 200;
    localparam int P_CYC = 400;
    localparam int P_ZI = 62;
    logic SYS_CLK = 1'b0, RSTN = 1'b0, RUN_HOLD = 1'b0, INPUT_POSITIVE = 1'b1, COMP_CROSSED;
    logic PHASE_ZERO_OFFSET, PHASE_SIGNAL_INTEGRATE, PHASE_REFERENCE_INTEGRATE;
    logic PHASE_INTEGRATOR_RESET, BUSY, OVERRANGE, UNDERRANGE, POLARITY, STROBE_N;
    logic DIGIT_SEL_MSD, DIGIT_SEL_FOURTH, DIGIT_SEL_THIRD, DIGIT_SEL_SECOND, DIGIT_SEL_LSD;
    logic BCD_WEIGHT_EIGHT, BCD_WEIGHT_FOUR, BCD_WEIGHT_TWO, BCD_WEIGHT_ONE;
    logic [4:0]  sel;
    logic [3:0]  bcd;
    logic [15:0] target = 16'h0000;
    int          fail_count = 0, compares = 0, strobes, value;
    assign sel = {DIGIT_SEL_MSD, DIGIT_SEL_FOURTH, DIGIT_SEL_THIRD,
                  DIGIT_SEL_SECOND, DIGIT_SEL_LSD};
    assign bcd = {BCD_WEIGHT_EIGHT, BCD_WEIGHT_FOUR, BCD_WEIGHT_TWO, BCD_WEIGHT_ONE};
    always #(CLK_PERIOD_NS / 2) SYS_CLK = ~SYS_CLK;
    dso_sequencer_top #(.P_CYCLE(16'(P_CYC)), .P_INT(16'(P_INT)), .P_FULL(15'(P_FULL)),
                        .P_ZI_LONG(16'(P_ZI))) dut (
        .SYS_CLK, .RSTN, .RUN_HOLD, .COMP_CROSSED, .INPUT_POSITIVE, .PHASE_ZERO_OFFSET,
        .PHASE_SIGNAL_INTEGRATE, .PHASE_REFERENCE_INTEGRATE, .PHASE_INTEGRATOR_RESET, .BUSY,
        .OVERRANGE, .UNDERRANGE, .POLARITY, .DIGIT_SEL_MSD, .DIGIT_SEL_FOURTH,
        .DIGIT_SEL_THIRD, .DIGIT_SEL_SECOND, .DIGIT_SEL_LSD, .BCD_WEIGHT_EIGHT,
        .BCD_WEIGHT_FOUR, .BCD_WEIGHT_TWO, .BCD_WEIGHT_ONE, .STROBE_N);
    dso_front_model model (.sys_clk(SYS_CLK), .phase_ref(PHASE_REFERENCE_INTEGRATE),
        .phase_idle(!BUSY), .target(target), .crossed(COMP_CROSSED), .strobe_n(STROBE_N),
        .bcd(bcd), .strobes(strobes), .value(value));

    task close_out;
        $display("Comparisons %0d, mismatches %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // One held-start measurement, then the strobed scan and the quiet scan after it, or a blank display after it on overrange.
    task automatic run_one(input int n, input logic pos, input logic ovr);
        int b, rd, len, str;
        @(posedge SYS_CLK);
        target         <= ovr ? 16'hffff : 16'(n);
        INPUT_POSITIVE <= pos;
        RUN_HOLD       <= 1'b1;
        b = 0;
        while (!BUSY && b < 100) begin
            @(negedge SYS_CLK);
            b++;
        end
        `CHK(BUSY, 1'b1)
        b = 1;
        @(posedge SYS_CLK);
        RUN_HOLD <= 1'b0;
        @(negedge SYS_CLK);
        while (BUSY && b < 3000) begin
            b++;
            @(negedge SYS_CLK);
        end
        rd = b / 2 - P_INT - 1;
        if (ovr) begin
            `CHK(b, 2 * (P_INT + P_FULL + 2))
            rd = 0;
        end else begin
            `CHK(rd + 1 >= n && rd <= n + 1, 1'b1)
            `CHK(POLARITY, pos)
            rd = n;
        end
        `CHK({OVERRANGE, UNDERRANGE}, {ovr, !ovr})
        repeat (2) @(negedge SYS_CLK);
        for (int k = 0; k < 5; k++) begin
            `CHK(bcd, 4'((rd / (10 ** (4 - k))) % 10))
            len = 0;
            str = -1;
            while (sel[4 - k] && len < 500) begin
                if (!STROBE_N && str < 0) str = len;
                len++;
                @(negedge SYS_CLK);
            end
            `CHK(len, (k == 0) ? 2 * MSD_SLOT_LEN : 2 * DIGIT_SLOT_LEN)
            `CHK(str, 2 * STROBE_SLOT + 1)
        end
        `CHK(strobes, 5)
        `CHK(value, rd)
        len = 0;
        repeat (2000) begin
            @(negedge SYS_CLK);
            len += int'(sel != 5'h00);
        end
        `CHK(strobes, 5)
        `CHK(len != 0, !ovr)
    endtask

    // Blank display after overrange until the next reference phase restarts the scan.
    task automatic ovr_recover();
        int w, act;
        @(posedge SYS_CLK);
        target   <= 16'h0020;
        RUN_HOLD <= 1'b1;
        w = 0;
        act = 0;
        while (!PHASE_REFERENCE_INTEGRATE && w < 1000) begin
            @(negedge SYS_CLK);
            act += int'(sel != 5'h00);
            w++;
        end
        `CHK(act, 0)
        repeat (4) @(negedge SYS_CLK);
        `CHK(sel, 5'h10)
        `CHK(OVERRANGE, 1'b0)
        @(posedge SYS_CLK);
        RUN_HOLD <= 1'b0;
        repeat (3000) @(negedge SYS_CLK);
    endtask

    // Free running: integrate starts a fixed cycle apart.
    task automatic free_run();
        int c;
        @(posedge SYS_CLK);
        target   <= 16'h0010;
        RUN_HOLD <= 1'b1;
        c = 0;
        while (!BUSY && c < 2000) begin
            @(negedge SYS_CLK);
            c++;
        end
        repeat (2) begin
            c = 0;
            while (BUSY && c < 2000) begin
                @(negedge SYS_CLK);
                c++;
            end
            while (!BUSY && c < 2000) begin
                @(negedge SYS_CLK);
                c++;
            end
            `CHK(c, 2 * P_CYC)
        end
        @(posedge SYS_CLK);
        RUN_HOLD <= 1'b0;
        repeat (3000) @(negedge SYS_CLK);
    endtask

    initial begin
        repeat (8) @(negedge SYS_CLK);
        `CHK({PHASE_ZERO_OFFSET, BUSY, OVERRANGE, UNDERRANGE, POLARITY,
              DIGIT_SEL_MSD, STROBE_N}, 7'h47)
        @(posedge SYS_CLK);
        RSTN <= 1'b1;
        repeat (20) @(negedge SYS_CLK);
        run_one(0, 1'b0, 1'b0);
        run_one(187, 1'b1, 1'b0);
        run_one(0, 1'b1, 1'b1);
        ovr_recover();
        free_run();
        close_out();
    end

    // Whole run needs about 21000 clocks; allow more than twice that.
    initial begin
        repeat (50000) @(posedge SYS_CLK);
        fail_count++;
        close_out();
    end
endmodule
